// File: rtl/dlj_pkg.sv
// constants shared by the display-list jump sequencer and its console fifo
package dlj_pkg;
  // word and address geometry
  localparam int          WORD_W      = 12;
  localparam int          ADDR_W      = 13;
  localparam logic [12:0] ADDR_FIRST  = 13'h0000;
  localparam logic [12:0] ADDR_LAST   = 13'h1000;
  localparam logic [12:0] ADDR_STEP   = 13'h0001;
  // command words that redirect or end the fetch address
  localparam logic [11:0] CMD_SJUMP   = 12'h1C8;
  localparam logic [11:0] CMD_CALL    = 12'h1E8;
  localparam logic [11:0] CMD_PJUMP   = 12'h1D8;
  localparam logic [11:0] RETURN_CMD  = 12'h1FA;
  localparam logic [11:0] FRAME_END_BYTE = 12'h1F8;
  // beam reset word: top nibble, light pen bit, intensity field
  localparam logic [3:0]  RESET_TAG   = 4'h8;
  localparam int          RESET_TAG_LSB = 8;
  localparam int          LPEN_BIT    = 6;
  localparam int          INT_LSB     = 0;
  localparam int          INT_W       = 2;
  // increment word: beam bit, scale field, delta x, delta y
  localparam int          BEAM_BIT    = 11;
  localparam int          SCALE_LSB   = 8;
  localparam int          SCALE_W     = 3;
  localparam logic [2:0]  SCALE_MIN   = 3'h2;
  localparam int          DX_LSB      = 4;
  localparam int          DY_LSB      = 0;
  localparam int          DELTA_W     = 4;
  // intensity levels sent to the console
  localparam logic [1:0]  INT_DIM     = 2'h1;
  localparam logic [1:0]  INT_MEDIUM  = 2'h2;
  localparam logic [1:0]  INT_BRIGHT  = 2'h3;
  // frame refresh timing
  localparam int          REFRESH_US  = 25000;
  localparam int          CLK_MHZ     = 200;
  localparam int          REFRESH_CYC = REFRESH_US * CLK_MHZ;
  // console record: {x, y, beam_on, intensity, light pen enable}
  localparam int          REC_W       = 2 * WORD_W + 1 + INT_W + 1;
  localparam int          FIFO_DEPTH  = 4;
  // fetch phases
  typedef enum logic [1:0] {DLJ_PH_BYTE, DLJ_PH_TARGET, DLJ_PH_X, DLJ_PH_Y}
    dlj_phase_e;
  typedef enum logic [1:0] {DLJ_JK_SJUMP, DLJ_JK_CALL, DLJ_JK_PJUMP}
    dlj_jump_e;
endpackage

// File: rtl/dlj_fifo.sv
// small synchronous fifo between the sequencer and the console
`timescale 1ns/1ps
`default_nettype none
module dlj_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,  // system clock
  input  wire logic             rst_n,     // sync reset, active low
  input  wire logic [WIDTH-1:0] in_data,   // record to store
  input  wire logic             in_valid,  // record offered
  output logic                  in_ready,  // room for a record
  output logic      [WIDTH-1:0] out_data,  // oldest record
  output logic                  out_valid, // a record is held
  input  wire logic             out_ready  // consumer takes the record
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  wire              push;
  wire              pop;

  // handshake decode
  assign in_ready  = (count_reg != CNT_FULL);
  assign out_valid = (count_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  // pointer step with wrap at the depth
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // storage
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  // pointers and fill count
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= bump(wr_ptr_reg);
      if (pop)
        rd_ptr_reg <= bump(rd_ptr_reg);
      if (push && !pop)
        count_reg <= count_reg + (PW+1)'(1);
      else if (pop && !push)
        count_reg <= count_reg - (PW+1)'(1);
    end
  end
endmodule
`default_nettype wire

// File: rtl/dlj_sequencer.sv
// display-list sequencer: fetches, jumps, beam control toward the console
`timescale 1ns/1ps
`default_nettype none
module dlj_sequencer
  import dlj_pkg::*;
#(
  parameter int REFRESH_CYCLES = dlj_pkg::REFRESH_CYC,
  parameter int DEPTH          = dlj_pkg::FIFO_DEPTH
) (
  input  wire logic                       core_clk,      // system clock
  input  wire logic                       rst_n,         // sync reset, low
  input  wire logic                       start_disp,    // host start pulse
  input  wire logic                       status_rd,     // host reads status
  output logic                            frame_end_irq, // interrupt to host
  output logic                            busy,          // frame in progress
  output logic [dlj_pkg::ADDR_W-1:0]      mem_addr,      // fetch address
  output logic                            mem_req,       // read strobe
  input  wire logic [dlj_pkg::WORD_W-1:0] mem_rdata,     // word read back
  input  wire logic                       mem_rvalid,    // read data valid
  output logic [dlj_pkg::WORD_W-1:0]      beam_x,        // beam x position
  output logic [dlj_pkg::WORD_W-1:0]      beam_y,        // beam y position
  output logic                            beam_on,       // beam drawn
  output logic [dlj_pkg::INT_W-1:0]       intensity,     // brightness level
  output logic                            lpen_enable,   // light pen sense
  output logic                            con_valid,     // move offered
  input  wire logic                       con_ready      // console takes it
);
  import dlj_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum {DLJ_IDLE, DLJ_READ, DLJ_WAIT, DLJ_PUSH} dlj_state_e;

  dlj_state_e        state_reg;
  dlj_phase_e        phase_reg;
  dlj_jump_e         jump_reg;
  logic [ADDR_W-1:0] pc_reg;
  logic [ADDR_W-1:0] rp_reg;
  logic [WORD_W-1:0] x_reg;
  logic [WORD_W-1:0] y_reg;
  logic              beam_reg;
  logic [INT_W-1:0]  int_reg;
  logic              lpen_reg;
  logic              irq_reg;
  logic              run_reg;
  logic [31:0]       tick_reg;

  // ---------------------------------------------------------------
  // decode of the fetched word
  // ---------------------------------------------------------------
  wire [WORD_W-1:0]  w = mem_rdata;
  wire               is_sjump = (w == CMD_SJUMP);
  wire               is_call  = (w == CMD_CALL);
  wire               is_pjump = (w == CMD_PJUMP);
  wire               is_ret   = (w == RETURN_CMD);
  wire               is_end   = (w == FRAME_END_BYTE);
  wire               is_reset = (w[WORD_W-1:RESET_TAG_LSB] == RESET_TAG);
  wire [SCALE_W-1:0] scale    = w[SCALE_LSB +: SCALE_W];
  wire               is_incr  = !is_reset && (scale >= SCALE_MIN);
  wire [INT_W-1:0]   rst_int  = w[INT_LSB +: INT_W];
  wire [ADDR_W-1:0]  pc_inc   = pc_reg + ADDR_STEP;
  wire [ADDR_W-1:0]  rp_inc   = rp_reg + ADDR_STEP;
  wire [ADDR_W-1:0]  target   = {{(ADDR_W-WORD_W){1'b0}}, w};
  wire               got      = (state_reg == DLJ_WAIT) && mem_rvalid;
  wire               refresh  = (tick_reg == 32'(REFRESH_CYCLES - 1));
  wire               fifo_in_ready;
  wire [REC_W-1:0]   fifo_out;

  // sign-magnitude delta scaled by two to the (scale - 2)
  function automatic logic [WORD_W-1:0] scaled_delta(
    input logic [DELTA_W-1:0] d,
    input logic [SCALE_W-1:0] s
  );
    logic [WORD_W-1:0] mag;
    mag = {{(WORD_W-DELTA_W+1){1'b0}}, d[DELTA_W-2:0]};
    mag = mag << (s - SCALE_MIN);
    scaled_delta = d[DELTA_W-1] ? (~mag + WORD_W'(1)) : mag;
  endfunction

  wire [WORD_W-1:0] x_step = scaled_delta(w[DX_LSB +: DELTA_W], scale);
  wire [WORD_W-1:0] y_step = scaled_delta(w[DY_LSB +: DELTA_W], scale);

  // ---------------------------------------------------------------
  // frame timer and host handshake
  // ---------------------------------------------------------------
  // refresh period counter, free running once the host has started
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !run_reg || refresh)
      tick_reg <= '0;
    else
      tick_reg <= tick_reg + 32'h0000_0001;
  end

  // interrupt flag: a new end byte beats a simultaneous status read
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      irq_reg <= 1'b0;
    else if (got && phase_reg == DLJ_PH_BYTE && is_end)
      irq_reg <= 1'b1;
    else if (status_rd)
      irq_reg <= 1'b0;
  end

  // run latch set by the host start write
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      run_reg <= 1'b0;
    else if (start_disp)
      run_reg <= 1'b1;
  end

  // ---------------------------------------------------------------
  // fetch sequencer
  // ---------------------------------------------------------------
  // fetch, decode and jump control
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= DLJ_IDLE;
      phase_reg <= DLJ_PH_BYTE;
      jump_reg  <= DLJ_JK_SJUMP;
      pc_reg    <= ADDR_FIRST;
      rp_reg    <= ADDR_FIRST;
    end
    else
    begin
      case (state_reg)
        DLJ_IDLE:
        begin
          if (start_disp || (run_reg && refresh))
          begin
            pc_reg    <= ADDR_FIRST;
            phase_reg <= DLJ_PH_BYTE;
            state_reg <= DLJ_READ;
          end
        end
        DLJ_READ:
        begin
          if (pc_reg > ADDR_LAST)
            state_reg <= DLJ_IDLE;
          else
            state_reg <= DLJ_WAIT;
        end
        DLJ_WAIT:
        begin
          if (mem_rvalid)
          begin
            state_reg <= DLJ_READ;
            case (phase_reg)
              DLJ_PH_BYTE:
              begin
                pc_reg <= pc_inc;
                if (is_sjump)
                begin
                  jump_reg  <= DLJ_JK_SJUMP;
                  phase_reg <= DLJ_PH_TARGET;
                end
                else if (is_call)
                begin
                  jump_reg  <= DLJ_JK_CALL;
                  phase_reg <= DLJ_PH_TARGET;
                end
                else if (is_pjump)
                begin
                  jump_reg  <= DLJ_JK_PJUMP;
                  pc_reg    <= rp_inc;
                  phase_reg <= DLJ_PH_TARGET;
                end
                else if (is_ret)
                  pc_reg <= rp_inc;
                else if (is_end)
                  state_reg <= DLJ_IDLE;
                else if (is_reset)
                  phase_reg <= DLJ_PH_X;
                else if (is_incr)
                  state_reg <= DLJ_PUSH;
              end
              DLJ_PH_TARGET:
              begin
                phase_reg <= DLJ_PH_BYTE;
                if (target > ADDR_LAST)
                  state_reg <= DLJ_IDLE;
                pc_reg <= target;
                if (jump_reg != DLJ_JK_SJUMP)
                  rp_reg <= pc_reg;
              end
              DLJ_PH_X:
              begin
                pc_reg    <= pc_inc;
                phase_reg <= DLJ_PH_Y;
              end
              default:
              begin
                pc_reg    <= pc_inc;
                phase_reg <= DLJ_PH_BYTE;
                state_reg <= DLJ_PUSH;
              end
            endcase
          end
        end
        DLJ_PUSH:
        begin
          if (fifo_in_ready)
            state_reg <= DLJ_READ;
        end
        default:
          state_reg <= DLJ_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // beam state
  // ---------------------------------------------------------------
  // position, beam, intensity and light pen updates
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      x_reg    <= '0;
      y_reg    <= '0;
      beam_reg <= 1'b0;
      int_reg  <= INT_MEDIUM;
      lpen_reg <= 1'b0;
    end
    else if (got)
    begin
      if (phase_reg == DLJ_PH_BYTE && is_reset)
      begin
        beam_reg <= 1'b0;
        int_reg  <= (rst_int == '0) ? INT_MEDIUM : rst_int;
        lpen_reg <= w[LPEN_BIT];
      end
      else if (phase_reg == DLJ_PH_BYTE && is_incr)
      begin
        beam_reg <= w[BEAM_BIT];
        x_reg    <= x_reg + x_step;
        y_reg    <= y_reg + y_step;
      end
      else if (phase_reg == DLJ_PH_X)
        x_reg <= w;
      else if (phase_reg == DLJ_PH_Y)
        y_reg <= w;
    end
  end

  // ---------------------------------------------------------------
  // console fifo and outputs
  // ---------------------------------------------------------------
  dlj_fifo #(
    .WIDTH (REC_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_data   ({x_reg, y_reg, beam_reg, int_reg, lpen_reg}),
    .in_valid  (state_reg == DLJ_PUSH),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (con_valid),
    .out_ready (con_ready)
  );

  // output decode
  assign beam_x        = fifo_out[REC_W-1 -: WORD_W];
  assign beam_y        = fifo_out[REC_W-1-WORD_W -: WORD_W];
  assign beam_on       = fifo_out[INT_W+1];
  assign intensity     = fifo_out[1 +: INT_W];
  assign lpen_enable   = fifo_out[0];
  assign mem_addr      = pc_reg;
  assign mem_req       = (state_reg == DLJ_READ) && (pc_reg <= ADDR_LAST);
  assign frame_end_irq = irq_reg;
  assign busy          = (state_reg != DLJ_IDLE);
endmodule
`default_nettype wire

// File: dv/dlj_sequencer_sva.sv
// port assertions for the display-list sequencer
`timescale 1ns/1ps
`default_nettype none
module dlj_sequencer_sva
  import dlj_pkg::*;
#(
  parameter int REFRESH_CYCLES = 200,
  parameter int DEPTH          = 4
) (
  input wire logic                       core_clk,      // clock
  input wire logic                       rst_n,         // reset, low
  input wire logic                       start_disp,    // host start
  input wire logic                       status_rd,     // status read
  input wire logic                       frame_end_irq, // interrupt
  input wire logic                       busy,          // frame runs
  input wire logic [dlj_pkg::ADDR_W-1:0] mem_addr,      // fetch address
  input wire logic                       mem_req,       // read strobe
  input wire logic [dlj_pkg::WORD_W-1:0] mem_rdata,     // read word
  input wire logic                       mem_rvalid     // word valid
);
  logic wait_reg;
  logic wait_next;
  // ----------------------------------------
  // outstanding read tracker
  // ----------------------------------------
  assign wait_next = mem_req | (wait_reg & ~mem_rvalid);
  // set by a request, cleared by its answer
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      wait_reg <= 1'b0;
    else
      wait_reg <= wait_next;
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_start;
    start_disp && !busy |=> mem_req && mem_addr == ADDR_FIRST;
  endproperty
  a_start: assert property (p_start) else $error("no fetch at zero");
  property p_req_pulse;
    mem_req |=> !mem_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("long strobe");
  property p_hold;
    wait_reg |-> !mem_req && $stable(mem_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_range;
    mem_req |-> mem_addr <= ADDR_LAST;
  endproperty
  a_range: assert property (p_range) else $error("fetch out of range");
  property p_step;
    mem_rvalid && mem_rdata == 12'h000 |=>
      mem_req && mem_addr == $past(mem_addr) + ADDR_STEP;
  endproperty
  a_step: assert property (p_step) else $error("no advance");
  property p_jump;
    mem_rvalid && (mem_rdata == CMD_SJUMP || mem_rdata == CMD_CALL) |=>
      mem_req && mem_addr == $past(mem_addr) + ADDR_STEP;
  endproperty
  a_jump: assert property (p_jump) else $error("target not read");
  property p_end;
    mem_rvalid && mem_rdata == FRAME_END_BYTE |=> !busy && frame_end_irq;
  endproperty
  a_end: assert property (p_end) else $error("end not taken");
  property p_irq;
    frame_end_irq |=> (frame_end_irq == !$past(status_rd)) || $past(mem_rvalid);
  endproperty
  a_irq: assert property (p_irq) else $error("irq hold or clear");
endmodule
bind dlj_sequencer dlj_sequencer_sva #(
  .REFRESH_CYCLES(REFRESH_CYCLES), .DEPTH(DEPTH)
) u_sva (
  .core_clk(core_clk), .rst_n(rst_n), .start_disp(start_disp),
  .status_rd(status_rd), .frame_end_irq(frame_end_irq), .busy(busy),
  .mem_addr(mem_addr), .mem_req(mem_req), .mem_rdata(mem_rdata),
  .mem_rvalid(mem_rvalid)
);
`default_nettype wire

// File: dv/dlj_buffer_mem.sv
// behavioural buffer memory answering the sequencer's fetches
`timescale 1ns/1ps
`default_nettype none
module dlj_buffer_mem
  import dlj_pkg::*;
(
  input  wire logic                       core_clk,  // clock
  input  wire logic                       rst_n,     // reset, low
  input  wire logic [dlj_pkg::ADDR_W-1:0] mem_addr,  // fetch address
  input  wire logic                       mem_req,   // read strobe
  output logic      [dlj_pkg::WORD_W-1:0] mem_rdata, // read word
  output logic                            mem_rvalid // word valid
);
  logic [WORD_W-1:0] core [0:4096];
  logic [ADDR_W-1:0] addr_reg;
  logic              pend_reg = 1'b0;
  int                wait_cnt;
  // one word per request after one to four cycles; data toggles otherwise
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pend_reg   <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata  <= 12'h000;
    end
    else if (mem_req && !pend_reg)
    begin
      pend_reg   <= 1'b1;
      addr_reg   <= mem_addr;
      wait_cnt   <= $urandom_range(3);
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata;
    end
    else if (pend_reg && wait_cnt > 0)
    begin
      wait_cnt   <= wait_cnt - 1;
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata;
    end
    else if (pend_reg)
    begin
      pend_reg   <= 1'b0;
      mem_rvalid <= 1'b1;
      mem_rdata  <= (addr_reg <= ADDR_LAST) ? core[addr_reg] : 12'hFFF;
    end
    else
    begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// File: dv/dlj_sequencer_test.sv
// self-checking bench for the display-list sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) chk((a), (b))
`define WAIT(c) begin int k; for (k = 0; k < 6000 && !(c); k++) \
  begin @(posedge core_clk); #1; end \
  if (k == 6000) begin n_fail++; finish_test(); end end
module dlj_sequencer_test;
  import dlj_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              start_disp = 1'b0;
  logic              status_rd = 1'b0;
  logic              con_ready = 1'b0;
  logic              stall = 1'b0;
  logic              frame_end_irq, busy, mem_req, mem_rvalid;
  logic              beam_on, lpen_enable, con_valid;
  logic [ADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_rdata, beam_x, beam_y, rw;
  logic [INT_W-1:0]  intensity;
  logic [REC_W-1:0]  rec_out;
  logic [ADDR_W-1:0] ea_q[$];
  logic [REC_W-1:0]  rq[$];
  int                n_fail = 0;
  int                samples_checked = 0;
  assign rec_out = {beam_x, beam_y, beam_on, intensity, lpen_enable};
  always #2.5 core_clk = ~core_clk;
  dlj_sequencer #(.REFRESH_CYCLES(3000), .DEPTH(4)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .start_disp(start_disp),
    .status_rd(status_rd), .frame_end_irq(frame_end_irq), .busy(busy),
    .mem_addr(mem_addr), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .beam_x(beam_x), .beam_y(beam_y),
    .beam_on(beam_on), .intensity(intensity), .lpen_enable(lpen_enable),
    .con_valid(con_valid), .con_ready(con_ready));
  dlj_buffer_mem u_mem (.core_clk(core_clk), .rst_n(rst_n),
    .mem_addr(mem_addr), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid));
  task automatic chk(logic [31:0] got, logic [31:0] want);
    samples_checked++;
    if (got !== want)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // signed sign-magnitude delta scaled by the step factor
  function automatic logic [11:0] step(logic [3:0] d, logic [2:0] s);
    logic [11:0] m;
    m = {9'h000, d[2:0]} << (s - SCALE_MIN);
    return d[3] ? -m : m;
  endfunction
  // walk the list in memory, queue expected fetches and console records
  task automatic ref_frame();
    logic [12:0] pc, rp, a;
    logic [11:0] w, x, y;
    logic [1:0]  lv;
    logic        lp;
    pc = ADDR_FIRST;
    rp = 13'h0000;
    for (int k = 0; k < 100; k++)
    begin
      w = u_mem.core[pc];
      ea_q.push_back(pc);
      if (w == FRAME_END_BYTE)
        return;
      if (w == CMD_SJUMP || w == CMD_CALL || w == CMD_PJUMP)
      begin
        a = (w == CMD_PJUMP) ? rp + ADDR_STEP : pc + ADDR_STEP;
        ea_q.push_back(a);
        rp = (w == CMD_SJUMP) ? rp : a;
        pc = {1'b0, u_mem.core[a]};
      end
      else if (w == RETURN_CMD)
        pc = rp + ADDR_STEP;
      else if (w[11:8] == RESET_TAG)
      begin
        ea_q.push_back(pc + 13'h0001);
        ea_q.push_back(pc + 13'h0002);
        x = u_mem.core[pc + 13'h0001];
        y = u_mem.core[pc + 13'h0002];
        lv = (w[1:0] == 2'h0) ? INT_MEDIUM : w[1:0];
        lp = w[LPEN_BIT];
        rq.push_back({x, y, 1'b0, lv, lp});
        pc = pc + 13'h0003;
      end
      else
      begin
        if (w[10:8] >= SCALE_MIN)
        begin
          x = x + step(w[7:4], w[10:8]);
          y = y + step(w[3:0], w[10:8]);
          rq.push_back({x, y, w[BEAM_BIT], lv, lp});
        end
        pc = pc + ADDR_STEP;
      end
    end
  endtask
  // console takes records at random, or not at all while stalled
  always @(posedge core_clk)
    con_ready <= ~stall & ($urandom_range(3) != 0);
  // compare every fetch address and every popped record
  always @(posedge core_clk)
  begin
    if (rst_n && mem_req)
    begin
      if (ea_q.size() == 0)
        ref_frame();
      `CHK(mem_addr, ea_q.pop_front());
    end
    if (rst_n && con_valid && con_ready)
    begin
      `CHK(rq.size() > 0, 1'b1);
      `CHK(rec_out, rq.pop_front());
    end
  end
  initial
  begin
    void'($urandom(47582));
    for (int a = 0; a <= 4096; a++)
      u_mem.core[a] = FRAME_END_BYTE;
    u_mem.core[0:4] = '{12'h802, 12'hDA7, 12'h258, CMD_SJUMP, 12'h010};
    u_mem.core[16:27] = '{12'hF77, 12'h2A3, 12'h52B, 12'hCFF, 12'h000,
      12'h100, 12'hE88, 12'hA11, CMD_CALL, 12'h020, 12'h030, 12'h1F8};
    u_mem.core[32:33] = '{12'h4C4, CMD_PJUMP};
    u_mem.core[48:54] = '{12'h841, 12'h100, 12'h200, 12'h803, 12'h005,
      12'h006, RETURN_CMD};
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    start_disp <= 1'b1;
    stall <= 1'b1;
    @(posedge core_clk);
    start_disp <= 1'b0;
    repeat (5) @(posedge core_clk);
    start_disp <= 1'b1;
    @(posedge core_clk);
    start_disp <= 1'b0;
    repeat (60) @(posedge core_clk);
    `CHK(busy, 1'b1);
    stall <= 1'b0;
    for (int f = 0; f < 5; f++)
    begin
      `WAIT(frame_end_irq === 1'b1)
      `CHK(busy, 1'b0);
      @(posedge core_clk);
      status_rd <= 1'b1;
      #1 `CHK(frame_end_irq, 1'b1);
      @(posedge core_clk);
      status_rd <= 1'b0;
      #1 `CHK(frame_end_irq, 1'b0);
      `WAIT(con_valid === 1'b0)
      `CHK(rq.size(), 0);
      `CHK(ea_q.size(), 0);
      for (int a = 16; a < 24; a++)
      begin
        rw = 12'($urandom);
        rw[10:8] = SCALE_MIN + 3'($urandom_range(5));
        u_mem.core[a] = rw;
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
